// ===== rtl/fdsd_top.sv
// FSK demodulators, post filter, clock recovery PLL and sync word matcher.
`timescale 1ns/10ps
`include "fdsd_cfg.svh"
// Operation
// R01: Select value 01 routes the dual-correlator discriminator to the slicer.
// R02: Select value 00 routes the linear frequency discriminator to the slicer.
// R03: Limited I/Q feed plus and minus deviation correlators; larger one decides.
// R04: Second-order low-pass after the discriminator, cutoff from ten-bit setting.
// R05: Software picks cutoff near 0.75 times the data rate.
// R06: Correlator slicer threshold is fixed at zero.
// R07: Oversampled PLL retimes bits; software sets oversample tick to 32x rate.
// R08: Recovery keeps lock with data rate off by up to two percent.
// R09: Correlator window follows ten-bit discriminator bandwidth setting.
// R10: Linear path: frequency value, averaging and envelope, then threshold.
// R11: Linear slicer decisions drive the clock recovery PLL.
// R12: Linear path shares the post filter bandwidth field and formula.
// R13: Sync word matched against stream raises the match indicator.
// R14: Indicator releases after nine recovered data clocks.
// R15: Sync detection only in demodulator modes 010 and 011.
// R16: Length field picks 12, 16, 20 or 24 compared bits.
// R17: Transmitter sends sync word most significant bit first.
// R18: Tolerance field accepts up to three disagreeing bits.
// R19: Length codes 00..11 map to 12..24 newest bits.
// R20: Tolerance value is the maximum mismatches; zero means exact.
module fdsd_top (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic demod_tick_i,
	input wire logic cdr_tick_i,
	input wire logic [1:0] iq_pin_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic hready_i,
	input wire logic [31:0] hwdata_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic match_indicator_o,
	output logic rec_data_o,
	output logic rec_clk_o
);
	import fdsd_pkg::*;
	fdsd_cfg_t cfg_reg;
	fdsd_ahb_req_t req;
	logic wr_pend_reg;
	logic [7:0] wr_addr_reg;
	logic [31:0] hrdata_reg;
	logic [1:0] sync1_reg, sync2_reg, sync3_reg, iq_reg;
	logic [1:0] quad_prev_reg;
	logic [1:0] quad_now;
	logic [1:0] quad_step;
	logic [9:0] pos_cnt_reg, neg_cnt_reg, win_cnt_reg;
	logic corr_dump;
	logic signed [15:0] corr_val_reg, disc_in;
	logic signed [15:0] stage_y [0:2];
	logic signed [15:0] filt_y, env_hi_reg, env_lo_reg, thresh;
	logic slice_w, slice_prev_reg, slice_reg;
	logic [4:0] phase_reg;
	logic rec_clk_reg, rec_data_reg;
	logic [23:0] shift_reg, len_mask, mism;
	logic [4:0] mism_count;
	logic sync_active, cmp_pend_reg, match_hit;
	fdsd_ind_state_t ind_state_reg;
	logic [3:0] ind_cnt_reg;

	// ==========================================================
	// AHB-Lite register slave, zero wait states, frozen with the clock enable.
	assign req = '{hsel_i, haddr_i, htrans_i, hwrite_i, hsize_i, hready_i, hwdata_i};
	assign hreadyout_o = ce_i;
	assign hresp_o = 1'b0;
	assign hrdata_o = hrdata_reg;
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			hrdata_reg <= 32'h0000_0000;
		end else if (ce_i) begin
			wr_pend_reg <= req.hsel && req.hready && req.htrans[1] && req.hwrite;
			wr_addr_reg <= req.haddr[7:0];
			if (req.hsel && req.hready && req.htrans[1] && !req.hwrite) begin
				case (req.haddr[7:0])
					`FDSD_OFS_CTRL: hrdata_reg <= {22'h00_0000, cfg_reg.rx_enable,
						cfg_reg.err_tol, cfg_reg.sync_len, cfg_reg.demod_mode,
						cfg_reg.demod_select};
					`FDSD_OFS_BW: hrdata_reg <= {6'h00, cfg_reg.discriminator_bandwidth_setting,
						6'h00, cfg_reg.post_filter_bandwidth_setting};
					`FDSD_OFS_SYNC: hrdata_reg <= {8'h00, cfg_reg.sync_word};
					`FDSD_OFS_STATUS: hrdata_reg <= {20'h0_0000, phase_reg, mism_count[3:0],
						slice_reg, rec_data_reg, match_indicator_o};
					default: hrdata_reg <= 32'h0000_0000;
				endcase
			end
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			cfg_reg <= '{`FDSD_SEL_LINEAR, 3'h0, 2'h0, 2'h0, 1'b0,
				`FDSD_RST_POST_BW, `FDSD_RST_DISC_BW, `FDSD_RST_SYNC};
		end else if (ce_i && wr_pend_reg) begin
			case (wr_addr_reg)
				`FDSD_OFS_CTRL: begin
					cfg_reg.demod_select <= req.hwdata[`FDSD_CTRL_SEL_LSB +: 2];
					cfg_reg.demod_mode <= req.hwdata[`FDSD_CTRL_MODE_LSB +: 3];
					cfg_reg.sync_len <= req.hwdata[`FDSD_CTRL_LEN_LSB +: 2];
					cfg_reg.err_tol <= req.hwdata[`FDSD_CTRL_TOL_LSB +: 2];
					cfg_reg.rx_enable <= req.hwdata[`FDSD_CTRL_RXEN_BIT];
				end
				`FDSD_OFS_BW: begin
					cfg_reg.post_filter_bandwidth_setting <= req.hwdata[`FDSD_BW_POST_LSB +: 10];
					cfg_reg.discriminator_bandwidth_setting <=
						req.hwdata[`FDSD_BW_DISC_LSB +: 10];
				end
				`FDSD_OFS_SYNC: cfg_reg.sync_word <= req.hwdata[23:0];
				default: cfg_reg <= cfg_reg;
			endcase
		end
	end

	// ==========================================================
	// Limiter inputs: three flops, a change counts once stages two and three agree.
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_pin
			always_ff @(posedge clk_sys_i) begin
				if (reset_i) begin
					sync1_reg[gi] <= 1'b0;
					sync2_reg[gi] <= 1'b0;
					sync3_reg[gi] <= 1'b0;
					iq_reg[gi] <= 1'b0;
				end else if (ce_i) begin
					sync1_reg[gi] <= iq_pin_i[gi];
					sync2_reg[gi] <= sync1_reg[gi];
					sync3_reg[gi] <= sync2_reg[gi];
					if (sync2_reg[gi] == sync3_reg[gi]) begin
						iq_reg[gi] <= sync3_reg[gi];
					end
				end
			end
		end
	endgenerate

	// ==========================================================
	// Discriminators. Quadrant rotation of the limited I/Q pair gives frequency sign.
	assign quad_now = {iq_reg[1], iq_reg[1] ^ iq_reg[0]};
	assign quad_step = quad_prev_reg - quad_now;
	assign corr_dump = demod_tick_i && (win_cnt_reg >= cfg_reg.discriminator_bandwidth_setting); // R09
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			quad_prev_reg <= 2'h0;
			pos_cnt_reg <= 10'h000;
			neg_cnt_reg <= 10'h000;
			win_cnt_reg <= 10'h000;
			corr_val_reg <= 16'sh0000;
		end else if (ce_i && demod_tick_i) begin
			quad_prev_reg <= quad_now;
			// Each correlator sums rotations toward its own tone over one window.
			if (corr_dump) begin // R03
				win_cnt_reg <= 10'h001;
				pos_cnt_reg <= 10'(quad_step == 2'h1);
				neg_cnt_reg <= 10'(quad_step == 2'h3);
				corr_val_reg <= {{3{1'b0}}, pos_cnt_reg, 3'h0} - {{3{1'b0}}, neg_cnt_reg, 3'h0};
			end else begin
				win_cnt_reg <= win_cnt_reg + 10'h001;
				pos_cnt_reg <= pos_cnt_reg + 10'(quad_step == 2'h1);
				neg_cnt_reg <= neg_cnt_reg + 10'(quad_step == 2'h3);
			end
		end
	end
	always_comb begin
		if (cfg_reg.demod_select == `FDSD_SEL_CORR) begin // R01
			disc_in = corr_val_reg;
		end else if (quad_step == 2'h1) begin // R10
			disc_in = `FDSD_LIN_STEP;
		end else if (quad_step == 2'h3) begin
			disc_in = -`FDSD_LIN_STEP;
		end else begin
			disc_in = 16'sh0000;
		end
	end

	// ==========================================================
	// Second-order post filter: two identical sections sharing one coefficient.
	assign stage_y[0] = disc_in;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_lpf
			fdsd_lpf_stage u_stage ( // R04 R12
				.clk_sys_i(clk_sys_i),
				.reset_i(reset_i),
				.en_i(ce_i && demod_tick_i),
				.k_i(cfg_reg.post_filter_bandwidth_setting),
				.x_i(stage_y[gi]),
				.y_o(stage_y[gi+1])
			);
		end
	endgenerate
	assign filt_y = stage_y[2];

	// ==========================================================
	// Envelope detector: peaks decay slowly so the mid level follows drift.
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			env_hi_reg <= 16'sh0000;
			env_lo_reg <= 16'sh0000;
		end else if (ce_i && demod_tick_i) begin // R10
			env_hi_reg <= (filt_y > env_hi_reg) ? filt_y :
				env_hi_reg - ((env_hi_reg - env_lo_reg) >>> 6);
			env_lo_reg <= (filt_y < env_lo_reg) ? filt_y :
				env_lo_reg + ((env_hi_reg - env_lo_reg) >>> 6);
		end
	end
	assign thresh = 16'((17'(env_hi_reg) + 17'(env_lo_reg)) >>> 1);
	// The correlator output is centred on zero, so run length cannot move its level.
	assign slice_w = (cfg_reg.demod_select == `FDSD_SEL_CORR) ? (filt_y > 16'sh0000) : // R06
		(filt_y > thresh); // R02 R10

	// ==========================================================
	// Clock recovery: 32 ticks per bit, one tick of correction per data edge.
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			phase_reg <= 5'h00;
			slice_reg <= 1'b0;
			slice_prev_reg <= 1'b0;
			rec_clk_reg <= 1'b0;
			rec_data_reg <= 1'b0;
		end else if (ce_i) begin
			rec_clk_reg <= 1'b0;
			if (cdr_tick_i) begin // R07 R11
				slice_reg <= slice_w;
				slice_prev_reg <= slice_reg;
				// Up to 1/32 of a bit per edge covers well over a two percent offset.
				if (slice_reg != slice_prev_reg && phase_reg != 5'h00) begin // R08
					phase_reg <= phase_reg[4] ? phase_reg + 5'h02 : phase_reg;
				end else begin
					phase_reg <= phase_reg + 5'h01;
				end
				if (phase_reg == `FDSD_PHASE_MID) begin
					rec_clk_reg <= 1'b1;
					rec_data_reg <= slice_reg;
				end
			end
		end
	end
	assign rec_clk_o = rec_clk_reg;
	assign rec_data_o = rec_data_reg;

	// ==========================================================
	// Sync word matcher on the newest recovered bits, oldest bit as the MSB.
	assign sync_active = cfg_reg.rx_enable && (cfg_reg.demod_mode == `FDSD_MODE_SYNC_A ||
		cfg_reg.demod_mode == `FDSD_MODE_SYNC_B); // R15
	generate
		for (gi = 0; gi < 24; gi++) begin : g_bit
			assign len_mask[gi] = (gi < 12 + 4 * cfg_reg.sync_len); // R16 R19
			assign mism[gi] = len_mask[gi] && (shift_reg[gi] ^ cfg_reg.sync_word[gi]);
		end
	endgenerate
	always_comb begin
		mism_count = 5'h00;
		for (int b = 0; b < 24; b++) begin
			mism_count = mism_count + 5'(mism[b]);
		end
	end
	assign match_hit = cmp_pend_reg && sync_active &&
		(mism_count <= {3'h0, cfg_reg.err_tol}); // R13 R18 R20
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			shift_reg <= 24'h00_0000;
			cmp_pend_reg <= 1'b0;
		end else if (ce_i) begin
			cmp_pend_reg <= rec_clk_reg;
			if (rec_clk_reg) begin // R17
				shift_reg <= {shift_reg[22:0], rec_data_reg};
			end
		end
	end
	// A new match while the pin is high restarts the nine-clock hold.
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			ind_state_reg <= FDSD_IND_IDLE;
			ind_cnt_reg <= 4'h0;
		end else if (ce_i) begin
			case (ind_state_reg)
				FDSD_IND_IDLE: begin
					if (match_hit) begin // R13
						ind_state_reg <= FDSD_IND_ACTIVE;
						ind_cnt_reg <= `FDSD_IND_HOLD;
					end
				end
				FDSD_IND_ACTIVE: begin
					if (match_hit) begin
						ind_cnt_reg <= `FDSD_IND_HOLD;
					end else if (rec_clk_reg) begin // R14
						ind_cnt_reg <= ind_cnt_reg - 4'h1;
						if (ind_cnt_reg == 4'h1) begin
							ind_state_reg <= FDSD_IND_IDLE;
						end
					end
				end
				default: ind_state_reg <= FDSD_IND_IDLE;
			endcase
		end
	end
	assign match_indicator_o = (ind_state_reg == FDSD_IND_ACTIVE);

	// ==========================================================
	// Checks.
	logic [3:0] aux_clks_reg;
	always_ff @(posedge clk_sys_i) begin
		if (reset_i || match_hit) begin
			aux_clks_reg <= 4'h0;
		end else if (ce_i && rec_clk_reg && aux_clks_reg != 4'hF) begin
			aux_clks_reg <= aux_clks_reg + 4'h1;
		end
	end
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i || !ce_i);
	property p_corr_slice;
		(cfg_reg.demod_select == `FDSD_SEL_CORR) |-> (slice_w == (filt_y > 16'sh0000));
	endproperty
	a_corr_slice: assert property (p_corr_slice) else $error("Correlator slice off zero."); // R06
	property p_lin_slice;
		(cfg_reg.demod_select == `FDSD_SEL_LINEAR) |-> (slice_w == (filt_y > thresh));
	endproperty
	a_lin_slice: assert property (p_lin_slice) else $error("Linear slice not on envelope."); // R02
	property p_corr_route;
		(cfg_reg.demod_select == `FDSD_SEL_CORR) |-> (disc_in == corr_val_reg);
	endproperty
	a_corr_route: assert property (p_corr_route) else $error("Correlator not routed."); // R01
	property p_release;
		$fell(match_indicator_o) |-> (aux_clks_reg == 4'h9) && $past(rec_clk_o);
	endproperty
	a_release: assert property (p_release) else $error("Indicator hold not nine clocks."); // R14
	property p_raise;
		match_hit |=> match_indicator_o ##0 (ind_cnt_reg == 4'h9);
	endproperty
	a_raise: assert property (p_raise) else $error("Match did not raise indicator."); // R13
	property p_mode_gate;
		match_hit |-> (cfg_reg.demod_mode inside {3'h2, 3'h3});
	endproperty
	a_mode_gate: assert property (p_mode_gate) else $error("Match outside sync modes."); // R15
	property p_tol;
		match_hit |-> (mism_count <= {3'h0, cfg_reg.err_tol});
	endproperty
	a_tol: assert property (p_tol) else $error("Match beyond tolerance."); // R18
	property p_len;
		$countones(len_mask) == 12 + 4 * cfg_reg.sync_len;
	endproperty
	a_len: assert property (p_len) else $error("Compared length wrong."); // R19
	property p_mid;
		rec_clk_o && $past(ce_i) |-> $past(phase_reg) == `FDSD_PHASE_MID && $past(cdr_tick_i);
	endproperty
	a_mid: assert property (p_mid) else $error("Bit not taken mid-phase."); // R07
	property p_rec_data;
		rec_clk_o && $past(ce_i) |-> rec_data_o == $past(slice_reg);
	endproperty
	a_rec_data: assert property (p_rec_data) else $error("Recovered bit not slicer bit."); // R11
	c_match: cover property (match_hit);
	c_release: cover property ($fell(match_indicator_o));
	c_dump: cover property (corr_dump && cfg_reg.demod_select == `FDSD_SEL_CORR);
	c_rec: cover property (rec_clk_o ##[120:136] rec_clk_o);
endmodule

// ===== rtl/fdsd_cfg.svh
// Constants of the FSK demodulator, clock recovery and sync word matcher.
`ifndef FDSD_CFG_SVH
`define FDSD_CFG_SVH
// ==========================================================
// Register byte offsets.
`define FDSD_OFS_CTRL 8'h00
`define FDSD_OFS_BW 8'h04
`define FDSD_OFS_SYNC 8'h08
`define FDSD_OFS_STATUS 8'h0C
// ==========================================================
// Control and bandwidth register field positions.
`define FDSD_CTRL_SEL_LSB 0
`define FDSD_CTRL_MODE_LSB 2
`define FDSD_CTRL_LEN_LSB 5
`define FDSD_CTRL_TOL_LSB 7
`define FDSD_CTRL_RXEN_BIT 9
`define FDSD_BW_POST_LSB 0
`define FDSD_BW_DISC_LSB 16
// ==========================================================
// Reset values.
`define FDSD_RST_CTRL 32'h0000_0000
`define FDSD_RST_POST_BW 10'h057
`define FDSD_RST_DISC_BW 10'h009
`define FDSD_RST_SYNC 24'h00_0000
// ==========================================================
// Encodings and timing counts.
`define FDSD_SEL_LINEAR 2'h0
`define FDSD_SEL_CORR 2'h1
`define FDSD_MODE_SYNC_A 3'h2
`define FDSD_MODE_SYNC_B 3'h3
`define FDSD_OVERSAMPLE 6'h20
`define FDSD_PHASE_MID 5'h10
`define FDSD_IND_HOLD 4'h9
`define FDSD_LIN_STEP 16'h0400
`endif

// ===== rtl/fdsd_pkg.sv
// Types shared by the FSK demodulator block.
package fdsd_pkg;
	typedef struct packed {
		logic [1:0] demod_select;
		logic [2:0] demod_mode;
		logic [1:0] sync_len;
		logic [1:0] err_tol;
		logic rx_enable;
		logic [9:0] post_filter_bandwidth_setting;
		logic [9:0] discriminator_bandwidth_setting;
		logic [23:0] sync_word;
	} fdsd_cfg_t;
	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic hready;
		logic [31:0] hwdata;
	} fdsd_ahb_req_t;
	typedef enum logic [1:0] {
		FDSD_IND_IDLE = 2'b01,
		FDSD_IND_ACTIVE = 2'b10
	} fdsd_ind_state_t;
endpackage

// ===== rtl/fdsd_lpf_stage.sv
// One first-order low-pass section of the post-demodulation filter.
`timescale 1ns/10ps
module fdsd_lpf_stage (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic en_i,
	input wire logic [9:0] k_i,
	input wire logic signed [15:0] x_i,
	output logic signed [15:0] y_o
);
	import fdsd_pkg::*;
	logic signed [27:0] acc_reg;
	logic signed [16:0] diff;
	logic signed [27:0] prod;
	// The coefficient is cutoff times 2^10 times 2 pi over the sample rate.
	assign diff = 17'(x_i) - 17'(y_o);
	assign prod = 28'(diff) * 28'($signed({1'b0, k_i}));
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			acc_reg <= 28'sh000_0000;
		end else if (en_i) begin
			acc_reg <= acc_reg + prod;
		end
	end
	assign y_o = acc_reg[25:10];
endmodule

// ===== tb/fdsd_tx_model.sv
// Remote FSK transmitter model that drives the limited quadrature levels.
`timescale 1ns/10ps
module fdsd_tx_model (
	input wire logic clk_i,
	input wire logic tick_i,
	output logic [1:0] iq_o
);
	// ==========================================================
	// Bit timing and pending bits.
	int bit_cyc = 128;
	int cnt = 0;
	logic cur = 1'b0;
	logic [1:0] ph = 2'h0;
	logic q[$];
	// Between words the model keeps sending a 1010 preamble, so the receiver stays locked.
	task automatic send(input logic [23:0] w, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			q.push_back(w[i]);
		end
	endtask
	always @(posedge clk_i) begin
		if (cnt >= bit_cyc - 1) begin
			cnt <= 0;
			cur <= (q.size() != 0) ? q.pop_front() : ~cur;
		end else begin
			cnt <= cnt + 1;
		end
		if (tick_i) begin
			ph <= cur ? ph + 2'h1 : ph - 2'h1;
		end
	end
	// A one bit turns the phasor forward a quarter turn per sample, a zero bit back.
	always_comb begin
		case (ph)
			2'h0: iq_o = 2'b11;
			2'h1: iq_o = 2'b01;
			2'h2: iq_o = 2'b00;
			default: iq_o = 2'b10;
		endcase
	end
endmodule

// ===== tb/tb.sv
// Self-checking bench for the FSK demodulator and sync word matcher.
`timescale 1ns/10ps
`include "fdsd_cfg.svh"
module tb;
	import fdsd_pkg::*;
	// ==========================================================
	// Clock, strobes, bus and scoreboard.
	localparam logic [23:0] SYNC = 24'hCA_5F38;
	logic clk_sys_i = 1'b0;
	logic reset_i = 1'b1;
	logic ce_i = 1'b1;
	logic demod_tick_i = 1'b0;
	logic cdr_tick_i = 1'b0;
	logic [1:0] iq_pin_i;
	logic hsel_i = 1'b0;
	logic [31:0] haddr_i = 32'h0000_0000;
	logic [1:0] htrans_i = 2'h0;
	logic hwrite_i = 1'b0;
	logic [2:0] hsize_i = 3'h2;
	logic [31:0] hwdata_i = 32'h0000_0000;
	logic [31:0] hrdata_o;
	logic hreadyout_o, hresp_o, match_indicator_o, rec_data_o, rec_clk_o;
	logic [1:0] tick_cnt = 2'h0;
	logic was_high = 1'b0;
	logic rd_phase = 1'b0;
	logic [31:0] q_rd[$];
	logic [31:0] q_ind[$];
	logic q_bit[$];
	int n_fail = 0;
	int samples_checked = 0;
	int pulses = 0;
	always #50 clk_sys_i = ~clk_sys_i;
	// Oversample strobe every 4 cycles gives 32 strobes in a 128-cycle bit.
	always @(posedge clk_sys_i) begin
		tick_cnt <= tick_cnt + 2'h1;
		demod_tick_i <= tick_cnt[0];
		cdr_tick_i <= (tick_cnt == 2'h3);
	end
	fdsd_top i_fdsd_top (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(ce_i),
		.demod_tick_i(demod_tick_i), .cdr_tick_i(cdr_tick_i), .iq_pin_i(iq_pin_i),
		.hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
		.hsize_i(hsize_i), .hready_i(hreadyout_o), .hwdata_i(hwdata_i), .hrdata_o(hrdata_o),
		.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .match_indicator_o(match_indicator_o),
		.rec_data_o(rec_data_o), .rec_clk_o(rec_clk_o));
	fdsd_tx_model i_fdsd_tx_model (.clk_i(clk_sys_i), .tick_i(demod_tick_i), .iq_o(iq_pin_i));
	// ==========================================================
	// Comparisons.
	task automatic cmp(input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL time %0t expected %h got %h", $time, exp, got);
		end
	endtask
	task automatic chk_reg(input logic [31:0] exp, input logic [31:0] got);
		cmp(exp, got);
	endtask
	task automatic chk_ind(input logic [31:0] exp, input logic [31:0] got);
		cmp(exp, got);
	endtask
	task automatic chk_bit(input logic exp, input logic got);
		cmp(32'(exp), 32'(got));
	endtask
	task automatic conclude();
		$display("Comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// ==========================================================
	// Output watchers: read data phases and indicator length in recovered clocks.
	always @(posedge clk_sys_i) begin
		if (rd_phase && hreadyout_o) begin
			chk_reg(q_rd.pop_front(), hrdata_o);
			chk_reg(32'h0000_0000, 32'(hresp_o));
		end
		if (hreadyout_o) rd_phase <= hsel_i && htrans_i[1] && !hwrite_i;
		if (!reset_i) begin
			if (match_indicator_o) begin
				if (!was_high && q_bit.size() != 0) chk_bit(q_bit.pop_front(), rec_data_o);
				if (rec_clk_o) pulses++;
			end else if (was_high) begin
				chk_ind((q_ind.size() != 0) ? q_ind.pop_front() : 32'h0, 32'(pulses));
				pulses = 0;
			end
			was_high = match_indicator_o;
		end
	end
	// ==========================================================
	// Bus master; the stall count drops the clock enable to stretch the data phase.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] exp, input int stall);
		hsel_i <= 1'b1;
		htrans_i <= 2'h2;
		haddr_i <= {24'h00_0000, a};
		hwrite_i <= w;
		@(posedge clk_sys_i);
		while (hreadyout_o !== 1'b1) @(posedge clk_sys_i);
		hsel_i <= 1'b0;
		htrans_i <= 2'h0;
		hwdata_i <= d;
		if (!w) q_rd.push_back(exp);
		if (stall != 0) ce_i <= 1'b0;
		repeat (stall) @(posedge clk_sys_i);
		ce_i <= 1'b1;
		@(posedge clk_sys_i);
		while (hreadyout_o !== 1'b1) @(posedge clk_sys_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 32'h0000_0000, 0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input int stall);
		bus(1'b0, a, 32'h0000_0000, exp, stall);
	endtask
	// One sync frame with a given number of corrupted bits at a given bit period.
	task automatic frame(input logic [9:0] ctrl, input int flips, input logic hit, input int bc);
		logic [23:0] mask;
		int len;
		len = 12 + 4 * ctrl[6:5];
		mask = 24'h00_0000;
		while ($countones(mask) < flips) mask[$urandom % len] = 1'b1;
		wr(`FDSD_OFS_CTRL, {22'h00_0000, ctrl});
		wr(`FDSD_OFS_SYNC, {8'h00, SYNC});
		i_fdsd_tx_model.bit_cyc = bc;
		// Four preamble bits let the filters and the PLL settle after a mode or rate change.
		repeat (4 * bc) @(posedge clk_sys_i);
		if (hit) begin
			q_ind.push_back(32'h0000_0009);
			q_bit.push_back(SYNC[0] ^ mask[0]);
		end
		i_fdsd_tx_model.send(SYNC ^ mask, len);
		repeat ((len + 12) * bc) @(posedge clk_sys_i);
		chk_ind(32'h0000_0000, 32'(q_ind.size()));
		i_fdsd_tx_model.bit_cyc = 128;
	endtask
	initial begin
		logic [31:0] r;
		r = $urandom(32'h8fc6_440a);
		repeat (8) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		@(posedge clk_sys_i);
		rd(`FDSD_OFS_CTRL, `FDSD_RST_CTRL, 0);
		rd(`FDSD_OFS_BW, {6'h00, `FDSD_RST_DISC_BW, 6'h00, `FDSD_RST_POST_BW}, 0);
		rd(`FDSD_OFS_SYNC, {8'h00, `FDSD_RST_SYNC}, 0);
		r = $urandom;
		wr(`FDSD_OFS_BW, r);
		rd(`FDSD_OFS_BW, r & 32'h03FF_03FF, 3);
		wr(8'h10, r);
		rd(8'h10, 32'h0000_0000, 0);
		r = $urandom;
		wr(`FDSD_OFS_CTRL, r);
		rd(`FDSD_OFS_CTRL, r & 32'h0000_03FF, 0);
		// Setting 1 fits a quarter-turn deviation; 75 puts the cutoff near 0.75 of the rate.
		wr(`FDSD_OFS_BW, 32'h0001_004B);
		repeat (2048) @(posedge clk_sys_i);
		for (int t = 0; t < 4; t++) frame({1'b1, 2'(t), 2'h3, 3'h2, 2'h1}, t, 1'b1, 128);
		frame({1'b1, 2'h3, 2'h3, 3'h2, 2'h1}, 4, 1'b0, 128);
		frame({1'b1, 2'h0, 2'h3, 3'h3, 2'h1}, 1, 1'b0, 128);
		for (int l = 0; l < 3; l++) frame({1'b1, 2'h0, 2'(l), 3'h3, 2'h1}, 0, 1'b1, 128);
		frame({1'b1, 2'h0, 2'h3, 3'h1, 2'h1}, 0, 1'b0, 128);
		frame({1'b0, 2'h0, 2'h3, 3'h2, 2'h1}, 0, 1'b0, 128);
		frame({1'b1, 2'h1, 2'h3, 3'h2, 2'h0}, 1, 1'b1, 128);
		frame({1'b1, 2'h0, 2'h3, 3'h3, 2'h1}, 0, 1'b1, 130);
		frame({1'b1, 2'h0, 2'h3, 3'h3, 2'h1}, 0, 1'b1, 126);
		conclude();
	end
	// A hang is cut short well past the expected run of about 71000 cycles.
	initial begin
		repeat (95000) @(posedge clk_sys_i);
		n_fail++;
		conclude();
	end
endmodule
